//--- rtl/tx_ctrl_pkg.sv
// Constants for the PCI transmit packet control block.
// Assumes a 10 MHz system clock and a slave register port at word offsets.
//
// Summary of operation
// - Controller-reset bit 31 holds the transmitter idle; registers stay accessible and unchanged except the packet counter, which clears.
// - FIFO-flush bit 30 empties the transmit FIFO, independent of controller reset.
// - Continuous mode bit 28 keeps the running address across packet restarts.
// - Packet counter counts finished packets only in continuous mode.
// - Bus-error enable bit 27 turns illegal register accesses into bus errors.
// - Bus-error enable never affects interrupts; illegal accesses never corrupt registers.
// - New beats start only while master enable bit 24 is high.
// - Bits 21, 20, 19 gate FIFO, illegal-state and retry-limit interrupts.
// - Bits 18, 17 gate target-abort and no-responder interrupts.
// - Bit 16 gates the clean-finish interrupt.
// - Upcoming address holds next byte address, advancing after each good beat.
// - Upcoming address loads the base address when software reloads it outside continuous mode or under controller reset.
// - Upcoming address stays correct after an abnormal termination.
// - Final-word register captures every word popped from the FIFO.
// - Packet-length write starts a packet only with master enable high, reset low.
// - Byte progress advances per beat, reads zero at restart, packet count increments.
// - Packet counter clears on controller reset or master enable drop mid-packet.
package tx_ctrl_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [15:0] OFF_SIZE    = 16'h8400;
	localparam logic [15:0] OFF_START   = 16'h8404;
	localparam logic [15:0] OFF_ENABLES = 16'h840c;
	localparam logic [15:0] OFF_NEXT    = 16'h8410;
	localparam logic [15:0] OFF_FINAL   = 16'h8414;
	localparam logic [15:0] OFF_DONE    = 16'h8418;
	localparam logic [15:0] OFF_STATUS  = 16'h841c;
	localparam logic [15:0] OFF_RSV_LO  = 16'h8420;
	localparam logic [15:0] OFF_RSV_HI  = 16'h843c;
	// ----------------------------------------
	// Field positions and masks
	// ----------------------------------------
	localparam int BIT_RESET = 31;
	localparam int BIT_FLUSH = 30;
	localparam int BIT_CONT  = 28;
	localparam int BIT_FAULT = 27;
	localparam int BIT_RUN   = 24;
	localparam int BIT_CLEAN    = 24;
	localparam int BIT_CLEAN_EN = 16;
	localparam logic [31:0] ENABLES_WMASK = 32'hd93f0000;
	localparam logic [31:0] SIZE_WMASK    = 32'hfffc0000;
	localparam logic [31:0] STATUS_RWC    = 32'h01ff0000;
	// ----------------------------------------
	// Reset values and steps
	// ----------------------------------------
	localparam logic [31:0] WORD_RST  = 32'h00000000;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [31:0] ADDR_STEP = 32'h00000004;
	localparam logic [15:0] BEAT_BYTES = 16'h0004;
	localparam logic [15:0] PKT_STEP  = 16'h0001;
	localparam int FIFO_DEPTH = 32;
	localparam int WORD_W     = 32;
	localparam int SYNC_W     = 5;
	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_BEAT} tx_state_t;
endpackage

//--- rtl/pci_tx_packet_control.sv
// Transmit packet controller: registers, FIFO, link synchroniser, beat engine.
// Assumes link pins are asynchronous to mclk and far slower (link clock edges
// are found by sampling).
`timescale 1ns/10ps

// ----------------------------------------
// Three-stage synchroniser with agreement filter
// ----------------------------------------
module sync3 #(parameter int N = 1)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [N-1:0] d,
	output logic      [N-1:0] q
);
	logic [N-1:0] s1, s2, s3;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			q  <= '0;
		end
		else
		begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q  <= (s2 & s3) | (q & (s2 | s3));
		end
	end
endmodule

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module tx_fifo #(parameter int W = 32, parameter int D = 32)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         flush,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic      [W-1:0] out_data,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW-1:0] rd, wr;
	logic [AW:0]   cnt, next_cnt;
	logic          push, pop;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd];
	assign out_valid = (cnt != '0);
	always_comb
	begin
		next_cnt = cnt;
		if (push && !pop)
			next_cnt = cnt + 1'b1;
		else if (pop && !push)
			next_cnt = cnt - 1'b1;
	end
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd <= '0;
			wr <= '0;
			cnt <= '0;
			in_ready <= 1'b0;
		end
		else if (flush)
		begin
			rd <= '0;
			wr <= '0;
			cnt <= '0;
			in_ready <= 1'b0;
		end
		else
		begin
			if (push)
				wr <= wr + 1'b1;
			if (pop)
				rd <= rd + 1'b1;
			cnt <= next_cnt;
			in_ready <= (next_cnt < (AW+1)'(D));
		end
	end
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr] <= in_data;
	end
endmodule

// ----------------------------------------
// Top
// ----------------------------------------
module pci_tx_packet_control
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Slave register port
	input  wire logic        reg_cs,
	input  wire logic        reg_we,
	input  wire logic [15:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	output logic             reg_ack,
	output logic             system_bus_error_ack,
	// DMA feed
	input  wire logic        feed_valid,
	input  wire logic [31:0] feed_data,
	output logic             feed_ready,
	// PCI link
	input  wire logic        pci_clk,
	input  wire logic        pci_beat_ack,
	input  wire logic        pci_target_abort,
	input  wire logic        pci_no_responder,
	input  wire logic        pci_retry_limit,
	output logic             pci_beat_req,
	output logic      [31:0] pci_beat_addr,
	output logic      [31:0] pci_beat_data,
	// Interrupt
	output logic             irq
);
	tx_ctrl_pkg::tx_state_t state;
	logic [31:0] tx_enables, tx_upcoming_address, tx_final_word, start_addr, size_reg, status;
	logic [15:0] bytes_done, packets_done;
	localparam int SYNC_W_L = tx_ctrl_pkg::SYNC_W;
	logic [SYNC_W_L-1:0] link_q;
	logic        link_prev, link_rise, run_prev, pkt_finished;
	logic        fifo_valid, fifo_pop;
	logic [31:0] fifo_data;
	logic        wr, rd, ro_wr, rsv_rd, rsv_wr, fault, restart, start_load;
	logic        beat_done, abort_hit, pkt_done, illegal, run_fell;
	logic [31:0] set_vec, clr_vec;
	logic        ctrl_reset, cont, run;

	assign ctrl_reset = tx_enables[tx_ctrl_pkg::BIT_RESET];
	assign cont = tx_enables[tx_ctrl_pkg::BIT_CONT];
	assign run = tx_enables[tx_ctrl_pkg::BIT_RUN];

	// ----------------------------------------
	// Link sampling
	// ----------------------------------------
	sync3 #(.N(SYNC_W_L)) u_sync
	(
		.clk   (mclk),
		.rst_n (rst_n),
		.d     ({pci_clk, pci_beat_ack, pci_target_abort, pci_no_responder, pci_retry_limit}),
		.q     (link_q)
	);
	assign link_rise = link_q[4] && !link_prev;
	assign beat_done = (state == tx_ctrl_pkg::ST_BEAT) && link_rise && link_q[3] && !(|link_q[2:0]);
	assign abort_hit = (state == tx_ctrl_pkg::ST_BEAT) && link_rise && (|link_q[2:0]);

	// ----------------------------------------
	// FIFO
	// ----------------------------------------
	tx_fifo #(.W(tx_ctrl_pkg::WORD_W), .D(tx_ctrl_pkg::FIFO_DEPTH)) u_fifo
	(
		.clk       (mclk),
		.rst_n     (rst_n),
		.flush     (tx_enables[tx_ctrl_pkg::BIT_FLUSH]),
		.in_valid  (feed_valid),
		.in_data   (feed_data),
		.in_ready  (feed_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (fifo_pop)
	);

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	assign wr = reg_cs && reg_we;
	assign rd = reg_cs && !reg_we;
	assign rsv_rd = rd && reg_addr >= tx_ctrl_pkg::OFF_RSV_LO && reg_addr <= tx_ctrl_pkg::OFF_RSV_HI;
	assign rsv_wr = wr && reg_addr >= tx_ctrl_pkg::OFF_RSV_LO && reg_addr <= tx_ctrl_pkg::OFF_RSV_HI;
	assign ro_wr = wr && (reg_addr == tx_ctrl_pkg::OFF_NEXT || reg_addr == tx_ctrl_pkg::OFF_FINAL
		|| reg_addr == tx_ctrl_pkg::OFF_DONE);
	assign fault = rsv_rd || rsv_wr || ro_wr;
	assign restart = wr && reg_addr == tx_ctrl_pkg::OFF_SIZE && run && !ctrl_reset;
	assign start_load = wr && reg_addr == tx_ctrl_pkg::OFF_START && (!cont || ctrl_reset);
	assign pkt_done = (state == tx_ctrl_pkg::ST_LOAD) && (bytes_done >= size_reg[31:16]);
	assign fifo_pop = (state == tx_ctrl_pkg::ST_LOAD) && !pkt_done && run && !ctrl_reset && fifo_valid;
	assign illegal = !(state inside {tx_ctrl_pkg::ST_IDLE, tx_ctrl_pkg::ST_LOAD, tx_ctrl_pkg::ST_BEAT});
	assign run_fell = run_prev && !run && state != tx_ctrl_pkg::ST_IDLE;
	assign set_vec = {7'h0, pkt_done, ro_wr, rsv_wr, rsv_rd,
		feed_valid && tx_enables[tx_ctrl_pkg::BIT_FLUSH], illegal,
		abort_hit && link_q[0], abort_hit && link_q[2], abort_hit && link_q[1], 16'h0};
	assign clr_vec = (wr && reg_addr == tx_ctrl_pkg::OFF_STATUS) ? (reg_wdata & tx_ctrl_pkg::STATUS_RWC) : 32'h0;

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_enables <= tx_ctrl_pkg::WORD_RST;
			start_addr <= tx_ctrl_pkg::WORD_RST;
			size_reg <= tx_ctrl_pkg::WORD_RST;
		end
		else if (wr)
		begin
			if (reg_addr == tx_ctrl_pkg::OFF_ENABLES)
				tx_enables <= reg_wdata & tx_ctrl_pkg::ENABLES_WMASK;
			if (reg_addr == tx_ctrl_pkg::OFF_START)
				start_addr <= reg_wdata;
			if (reg_addr == tx_ctrl_pkg::OFF_SIZE)
				size_reg <= reg_wdata & tx_ctrl_pkg::SIZE_WMASK;
		end
	end

	// Sticky status, set beats clear
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			status <= tx_ctrl_pkg::WORD_RST;
		else
			status <= (status & ~clr_vec) | set_vec;
	end

	// ----------------------------------------
	// Read answer and bus error
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_ack <= 1'b0;
			reg_rdata <= tx_ctrl_pkg::WORD_RST;
			system_bus_error_ack <= 1'b0;
		end
		else
		begin
			reg_ack <= reg_cs;
			system_bus_error_ack <= fault && tx_enables[tx_ctrl_pkg::BIT_FAULT];
			reg_rdata <= tx_ctrl_pkg::WORD_RST;
			if (rd)
			begin
				unique case (reg_addr)
					tx_ctrl_pkg::OFF_SIZE:    reg_rdata <= size_reg;
					tx_ctrl_pkg::OFF_START:   reg_rdata <= start_addr;
					tx_ctrl_pkg::OFF_ENABLES: reg_rdata <= tx_enables;
					tx_ctrl_pkg::OFF_NEXT:    reg_rdata <= tx_upcoming_address;
					tx_ctrl_pkg::OFF_FINAL:   reg_rdata <= tx_final_word;
					tx_ctrl_pkg::OFF_DONE:    reg_rdata <= {bytes_done, packets_done};
					tx_ctrl_pkg::OFF_STATUS:  reg_rdata <= status;
					default:                  reg_rdata <= tx_ctrl_pkg::WORD_RST;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Beat engine
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= tx_ctrl_pkg::ST_IDLE;
			pci_beat_req <= 1'b0;
			pci_beat_addr <= tx_ctrl_pkg::WORD_RST;
			pci_beat_data <= tx_ctrl_pkg::WORD_RST;
			link_prev <= 1'b0;
			run_prev <= 1'b0;
		end
		else
		begin
			link_prev <= link_q[4];
			run_prev <= run;
			if (ctrl_reset)
			begin
				state <= tx_ctrl_pkg::ST_IDLE;
				pci_beat_req <= 1'b0;
			end
			else if (restart)
			begin
				state <= tx_ctrl_pkg::ST_LOAD;
				pci_beat_req <= 1'b0;
			end
			else
			begin
				unique case (state)
					tx_ctrl_pkg::ST_IDLE: state <= tx_ctrl_pkg::ST_IDLE;
					tx_ctrl_pkg::ST_LOAD:
					begin
						if (pkt_done)
							state <= tx_ctrl_pkg::ST_IDLE;
						else if (fifo_pop)
						begin
							pci_beat_data <= fifo_data;
							pci_beat_addr <= tx_upcoming_address;
							pci_beat_req <= 1'b1;
							state <= tx_ctrl_pkg::ST_BEAT;
						end
					end
					tx_ctrl_pkg::ST_BEAT:
					begin
						if (beat_done)
						begin
							pci_beat_req <= 1'b0;
							state <= tx_ctrl_pkg::ST_LOAD;
						end
						else if (abort_hit)
						begin
							pci_beat_req <= 1'b0;
							state <= tx_ctrl_pkg::ST_IDLE;
						end
					end
					default:
					begin
						pci_beat_req <= 1'b0;
						state <= tx_ctrl_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// Address, final word, counts, interrupt
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			tx_upcoming_address <= tx_ctrl_pkg::WORD_RST;
		else if (start_load)
			tx_upcoming_address <= reg_wdata;
		else if (restart && !cont)
			tx_upcoming_address <= start_addr;
		else if (beat_done)
			tx_upcoming_address <= tx_upcoming_address + tx_ctrl_pkg::ADDR_STEP;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			tx_final_word <= tx_ctrl_pkg::WORD_RST;
		else if (fifo_pop)
			tx_final_word <= fifo_data;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bytes_done <= tx_ctrl_pkg::COUNT_RST;
			packets_done <= tx_ctrl_pkg::COUNT_RST;
			pkt_finished <= 1'b0;
		end
		else
		begin
			if (restart)
				bytes_done <= tx_ctrl_pkg::COUNT_RST;
			else if (beat_done)
				bytes_done <= bytes_done + tx_ctrl_pkg::BEAT_BYTES;
			if (ctrl_reset || run_fell)
				packets_done <= tx_ctrl_pkg::COUNT_RST;
			else if (restart && cont && pkt_finished)
				packets_done <= packets_done + tx_ctrl_pkg::PKT_STEP;
			if (restart || ctrl_reset)
				pkt_finished <= 1'b0;
			else if (pkt_done)
				pkt_finished <= 1'b1;
		end
	end

	// Bus-error enable is not an input here
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(status[20:16] & tx_enables[21:17])
				| (status[tx_ctrl_pkg::BIT_CLEAN] & tx_enables[tx_ctrl_pkg::BIT_CLEAN_EN]);
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	AST_RESET_HOLDS_IDLE: assert property (ctrl_reset |=> state == tx_ctrl_pkg::ST_IDLE && !pci_beat_req)
		else $error("controller reset did not stop the engine");
	AST_FLUSH_EMPTIES: assert property (tx_enables[tx_ctrl_pkg::BIT_FLUSH] |=> !fifo_valid && !feed_ready)
		else $error("flush left data in the FIFO");
	AST_CONT_KEEPS_ADDR: assert property (restart && cont && !start_load |=> $stable(tx_upcoming_address))
		else $error("continuous restart changed the address");
	AST_PKTS_ONLY_CONT: assert property ($changed(packets_done) |-> $past(cont) || packets_done == 16'h0)
		else $error("packet count moved outside continuous mode");
	AST_BUS_FAULT: assert property (fault && tx_enables[tx_ctrl_pkg::BIT_FAULT] |=> system_bus_error_ack && reg_ack)
		else $error("illegal access gave no bus error");
	AST_FAULT_NO_CORRUPT: assert property (fault |=> $stable(tx_enables) && $stable(start_addr))
		else $error("illegal access corrupted a register");
	AST_NO_TX_STOPPED: assert property (!run ##1 !run |-> !$rose(pci_beat_req))
		else $error("beat started with master enable low");
	AST_CLEAN_IRQ: assert property (status[tx_ctrl_pkg::BIT_CLEAN] && tx_enables[tx_ctrl_pkg::BIT_CLEAN_EN] |=> irq)
		else $error("clean finish interrupt missing");
	AST_ADDR_STEP: assert property (beat_done && !start_load && !restart
		|=> tx_upcoming_address == $past(tx_upcoming_address) + 32'h4)
		else $error("address did not advance by one word");
	AST_FINAL_WORD: assert property (fifo_pop |=> tx_final_word == $past(fifo_data) && pci_beat_req)
		else $error("popped word not captured");
	AST_RESTART_ZERO: assert property (restart |=> bytes_done == 16'h0 && state == tx_ctrl_pkg::ST_LOAD)
		else $error("restart did not begin a packet");
	AST_PKT_CLEAR: assert property (ctrl_reset |=> packets_done == 16'h0)
		else $error("packet count not cleared");

	COV_BEAT: cover property (fifo_pop ##[1:100] beat_done);
	COV_CLEAN: cover property (pkt_done ##1 status[tx_ctrl_pkg::BIT_CLEAN]);
	COV_ABORT: cover property (abort_hit ##1 state == tx_ctrl_pkg::ST_IDLE);
	COV_CONT: cover property (restart && cont && pkt_finished);
endmodule

//--- testbench/pci_target_model.sv
// Behavioural PCI target at the far side of the transmit link.
// Assumes beat requests are held until the link edge that answers them.
`timescale 1ns/10ps

module pci_target_model
(
	// Beat request from the controller
	input  wire logic       beat_req,
	// Answer selection from the bench
	input  wire logic [1:0] mode,
	input  wire logic       slow,
	// Link pins
	output logic            pci_clk,
	output logic            beat_ack,
	output logic            target_abort,
	output logic            no_responder,
	output logic            retry_limit
);
	// ----------------------------------------
	// One link clock pulse per offered beat
	// ----------------------------------------
	initial
	begin
		pci_clk = 1'b0;
		{beat_ack, target_abort, no_responder, retry_limit} = 4'h0;
		forever
		begin
			wait (beat_req === 1'b1);
			#(slow ? 1600 : 200);
			beat_ack = (mode == 2'd0);
			target_abort = (mode == 2'd1);
			no_responder = (mode == 2'd2);
			retry_limit = (mode == 2'd3);
			#400 pci_clk = 1'b1;
			wait (beat_req !== 1'b1);
			#400 pci_clk = 1'b0;
			// Answer lines are pulled low once the frame ends
			{beat_ack, target_abort, no_responder, retry_limit} = 4'h0;
		end
	end
endmodule

//--- testbench/pci_tx_packet_control_test.sv
// Self-checking bench for the transmit packet control block.
// Assumes the partner model answers every beat on the link pins.
`timescale 1ns/10ps

module pci_tx_packet_control_test;
	logic        mclk, rst_n, reg_cs, reg_we, feed_valid, feed_ready;
	logic [15:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, feed_data, pci_beat_addr, pci_beat_data;
	logic        reg_ack, system_bus_error_ack, pci_clk, pci_beat_ack, irq;
	logic        pci_target_abort, pci_no_responder, pci_retry_limit, pci_beat_req;
	logic [1:0]  mode;
	logic        slow, allow, req_q;
	logic [31:0] exp_q[$];
	logic [31:0] exp_addr, last_w, rd, base;
	logic        err;
	int          miscompares, total_checks, cycles, n, tot;
	logic [31:0] run = 32'h01000000;
	logic [31:0] cont = 32'h10000000;

	pci_tx_packet_control uut (.mclk(mclk), .rst_n(rst_n), .reg_cs(reg_cs), .reg_we(reg_we),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.system_bus_error_ack(system_bus_error_ack), .feed_valid(feed_valid), .feed_data(feed_data),
		.feed_ready(feed_ready), .pci_clk(pci_clk), .pci_beat_ack(pci_beat_ack),
		.pci_target_abort(pci_target_abort), .pci_no_responder(pci_no_responder),
		.pci_retry_limit(pci_retry_limit), .pci_beat_req(pci_beat_req),
		.pci_beat_addr(pci_beat_addr), .pci_beat_data(pci_beat_data), .irq(irq));

	pci_target_model far_end (.beat_req(pci_beat_req), .mode(mode), .slow(slow), .pci_clk(pci_clk),
		.beat_ack(pci_beat_ack), .target_abort(pci_target_abort), .no_responder(pci_no_responder),
		.retry_limit(pci_retry_limit));

	// ----------------------------------------
	// Clock, timeout, beat monitor
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			end_of_test;
		end
	end

	always @(posedge mclk)
	begin
		req_q <= pci_beat_req;
		if (pci_beat_req === 1'b1 && req_q !== 1'b1)
		begin
			check({31'h0, allow}, 32'h1);
			check(pci_beat_data, exp_q.size() ? exp_q.pop_front() : ~pci_beat_data);
			check(pci_beat_addr, exp_addr);
			if (mode == 2'd0)
				exp_addr += 32'h4;
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic acc(input logic we, input logic [15:0] a, input logic [31:0] wd);
		@(posedge mclk);
		reg_cs <= 1'b1;
		reg_we <= we;
		reg_addr <= a;
		reg_wdata <= wd;
		@(posedge mclk);
		reg_cs <= 1'b0;
		#1;
		rd = reg_rdata;
		err = system_bus_error_ack;
		check({31'h0, reg_ack}, 32'h1);
	endtask

	// Status flag expected for each abort answer of the far end
	function automatic logic [31:0] abort_flag(input int m);
		return m == 1 ? 32'h00020000 : m == 2 ? 32'h00010000 : 32'h00040000;
	endfunction

	task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0);
		check(rd, exp);
	endtask

	task automatic push(input int cnt);
		for (int i = 0; i < cnt; i++)
		begin
			last_w = $urandom;
			exp_q.push_back(last_w);
			feed_valid <= 1'b1;
			feed_data <= last_w;
			@(posedge mclk);
			while (feed_ready !== 1'b1) @(posedge mclk);
		end
		feed_valid <= 1'b0;
	endtask

	task automatic wait_status(input logic [31:0] mask);
		for (int i = 0; i < 1500; i++)
		begin
			acc(1'b0, tx_ctrl_pkg::OFF_STATUS, 32'h0);
			if ((rd & mask) != 0)
				return;
		end
		check(rd & mask, mask);
	endtask

	task automatic end_of_test;
		$display("total_checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		{rst_n, reg_cs, reg_we, feed_valid, slow, allow} = 6'h0;
		{reg_addr, reg_wdata, feed_data, exp_addr} = '0;
		mode = 2'd0;
		void'($urandom(36842));
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rdchk(tx_ctrl_pkg::OFF_ENABLES, 32'h0);
		rdchk(tx_ctrl_pkg::OFF_NEXT, 32'h0);
		rdchk(tx_ctrl_pkg::OFF_FINAL, 32'h0);
		rdchk(tx_ctrl_pkg::OFF_DONE, 32'h0);
		acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, 32'hffffffff);
		rdchk(tx_ctrl_pkg::OFF_ENABLES, 32'hd93f0000);
		// Illegal accesses with fault reporting off, then on
		for (int f = 0; f < 2; f++)
			for (int k = 0; k < 5; k++)
			begin
				acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, (f ? 32'h08000000 : 32'h0) | 32'h003f0000);
				acc(k != 0, k == 0 ? 16'h8420 : k == 1 ? 16'h843c : 16'h840c + 16'((k - 1) * 4), 32'hffffffff);
				check({31'h0, err}, 32'(f));
				rdchk(tx_ctrl_pkg::OFF_STATUS, 32'h1 << (k < 2 ? 21 + k : 23));
				check({31'h0, irq}, 32'h0);
				acc(1'b1, tx_ctrl_pkg::OFF_STATUS, 32'h01ff0000);
			end
		rdchk(tx_ctrl_pkg::OFF_NEXT, 32'h0);
		rdchk(tx_ctrl_pkg::OFF_FINAL, 32'h0);
		// Full buffer drained by a slow target
		base = $urandom & 32'hfffffffc;
		exp_addr = base;
		acc(1'b1, tx_ctrl_pkg::OFF_START, base);
		rdchk(tx_ctrl_pkg::OFF_NEXT, base);
		acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, run | 32'h00010000);
		push(32);
		@(posedge mclk);
		#1 check({31'h0, feed_ready}, 32'h0);
		slow = 1'b1;
		allow = 1'b1;
		acc(1'b1, tx_ctrl_pkg::OFF_SIZE, 32'h00800000);
		wait_status(32'h01000000);
		check({31'h0, irq}, 32'h1);
		rdchk(tx_ctrl_pkg::OFF_NEXT, base + 32'd128);
		rdchk(tx_ctrl_pkg::OFF_FINAL, last_w);
		rdchk(tx_ctrl_pkg::OFF_DONE, 32'h00800000);
		acc(1'b1, tx_ctrl_pkg::OFF_STATUS, 32'h01000000);
		repeat (2) @(posedge mclk);
		check({31'h0, irq}, 32'h0);
		// Continuous packets of random length
		slow = 1'b0;
		acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, 32'h80000000);
		base = $urandom & 32'hfffffffc;
		exp_addr = base;
		tot = 0;
		acc(1'b1, tx_ctrl_pkg::OFF_START, base);
		acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, cont | run);
		for (int k = 0; k < 3; k++)
		begin
			n = 1 + $urandom % 6;
			tot += n;
			push(n);
			acc(1'b1, tx_ctrl_pkg::OFF_START, $urandom);
			acc(1'b1, tx_ctrl_pkg::OFF_SIZE, 32'(n * 4) << 16);
			rdchk(tx_ctrl_pkg::OFF_DONE, 32'(k));
			wait_status(32'h01000000);
			acc(1'b1, tx_ctrl_pkg::OFF_STATUS, 32'h01000000);
		end
		rdchk(tx_ctrl_pkg::OFF_NEXT, base + 32'(tot * 4));
		// Master enable dropped mid-packet, then controller reset
		push(2);
		acc(1'b1, tx_ctrl_pkg::OFF_SIZE, 32'h00080000);
		acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, cont);
		allow = 1'b0;
		acc(1'b0, tx_ctrl_pkg::OFF_DONE, 32'h0);
		check({16'h0, rd[15:0]}, 32'h0);
		acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, 32'hc1000000);
		exp_q.delete();
		acc(1'b1, tx_ctrl_pkg::OFF_SIZE, 32'h00040000);
		repeat (30) @(posedge mclk);
		rdchk(tx_ctrl_pkg::OFF_ENABLES, 32'hc1000000);
		// Abort terminations, masked then unmasked
		for (int m = 1; m < 4; m++)
		begin
			acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, 32'h0);
			base = $urandom & 32'hfffffffc;
			exp_addr = base;
			acc(1'b1, tx_ctrl_pkg::OFF_START, base);
			acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, run);
			push(1);
			mode = 2'(m);
			allow = 1'b1;
			acc(1'b1, tx_ctrl_pkg::OFF_SIZE, 32'h00040000);
			wait_status(32'h00070000);
			check(rd, abort_flag(m));
			check({31'h0, irq}, 32'h0);
			acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, run | (abort_flag(m) << 1));
			repeat (2) @(posedge mclk);
			check({31'h0, irq}, 32'h1);
			rdchk(tx_ctrl_pkg::OFF_NEXT, base);
			rdchk(tx_ctrl_pkg::OFF_FINAL, last_w);
			acc(1'b1, tx_ctrl_pkg::OFF_STATUS, 32'h01ff0000);
			mode = 2'd0;
			allow = 1'b0;
		end
		// Master enable low, then flush with data offered
		acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, 32'h0);
		push(3);
		acc(1'b1, tx_ctrl_pkg::OFF_SIZE, 32'h000c0000);
		repeat (30) @(posedge mclk);
		acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, 32'h40200000);
		@(posedge mclk);
		feed_valid <= 1'b1;
		@(posedge mclk);
		feed_valid <= 1'b0;
		#1 check({31'h0, feed_ready}, 32'h0);
		rdchk(tx_ctrl_pkg::OFF_STATUS, 32'h00100000);
		check({31'h0, irq}, 32'h1);
		exp_q.delete();
		acc(1'b1, tx_ctrl_pkg::OFF_ENABLES, run);
		acc(1'b1, tx_ctrl_pkg::OFF_SIZE, 32'h00040000);
		repeat (30) @(posedge mclk);
		end_of_test;
	end
endmodule
